// ==== logic/ext_int_pkg.sv ====
// constants and carrier types for the extended control and interrupt group
// Overview of operation
// RULE1: last tx enable cleared by hard/soft reset
// RULE2: reserved fields read back as zero
// RULE3: own bus master errors set system flag
// RULE4: parity error sets flag regardless of response
// RULE5: system flag with enable drives request pin
// RULE6: pci status clears leave system flag
// RULE7: system flag write-one clear, hard/soft reset
// RULE8: system enable cleared by hard/soft reset
// RULE9: excessive deferral sets deferral flag
// RULE10: deferral flag with enable drives request
// RULE11: deferral flag write-one clear, hard reset
// RULE12: deferral enable cleared only by hard reset
// RULE13: accept bit clear needs station address match
// RULE14: accept bit set takes any destination
// RULE15: wake needs sixteen repeated station addresses
// RULE16: accept bit ored with its duplicate
// RULE17: accept bit cleared by hard/soft reset
// RULE18: valid wake frame in wake mode sets flag
// RULE19: wake flag requests only with both enables
// RULE20: wake flag cleared by write, resets, stop
// RULE21: wake enable gates summary, hard/soft reset
// RULE22: wake mode needs host enable and mode
// RULE23: summary ors enabled flags, drives pin
package ext_int_pkg;

    // ********************************
    // register map
    // ********************************
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] REG_CTRL_INT = 12'h014;
    localparam logic [ADDR_W-1:0] REG_WAKE_AUX = 12'h1D0;
    localparam logic [31:0] CTRL_INT_RESET = 32'h0000_0000;

    // ********************************
    // field positions
    // ********************************
    localparam int BIT_LAST_TX_EN = 14;
    localparam int BIT_SYS_FLAG = 11;
    localparam int BIT_SYS_EN = 10;
    localparam int BIT_EXD_FLAG = 7;
    localparam int BIT_EXD_EN = 6;
    localparam int BIT_ANY_ADDR = 5;
    localparam int BIT_WAKE_FLAG = 4;
    localparam int BIT_WAKE_EN = 3;
    localparam int BIT_WAKE_HOST = 2;
    localparam int BIT_WAKE_MODE = 1;
    localparam int BIT_ANY_ADDR_DUP = 6;

    // ********************************
    // wake frame shape
    // ********************************
    localparam int ADDR_BYTES = 6;
    localparam int ADDR_REPS = 16;

    // ********************************
    // carriers
    // ********************************
    typedef struct packed {
        logic parity;
        logic master_abort;
        logic target_abort;
    } bus_err_s;

    typedef struct packed {
        logic valid;
        logic start;
        logic last;
        logic good;
        logic [7:0] data;
    } rx_byte_s;

endpackage

// ==== logic/sticky_flag.sv ====
// write-one-clear event flag where a set beats any clear
`timescale 1ns/10ps
`default_nettype none
module sticky_flag (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // set and clear terms
    input wire logic set_evt,
    input wire logic clear_w1c,
    input wire logic clear_sync,
    // flag
    output logic flag
);
    // ********************************
    // flag storage
    // ********************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            flag <= 1'b0;
        end else if (set_evt) begin
            flag <= 1'b1;
        end else if (clear_w1c || clear_sync) begin
            flag <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== logic/wake_frame_matcher.sv ====
// wake frame recogniser: destination check plus repeated station address
`timescale 1ns/10ps
`default_nettype none
module wake_frame_matcher
    import ext_int_pkg::*;
#(
    parameter int NBYTES = ADDR_BYTES,
    parameter int NREPS = ADDR_REPS
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // receive byte stream
    input wire ext_int_pkg::rx_byte_s rx,
    // configuration
    input wire logic [8*NBYTES-1:0] station_phys_address,
    input wire logic any_accept,
    input wire logic mode_active,
    // result
    output logic frame_hit
);
    import ext_int_pkg::*;
    localparam int IW = $clog2(NBYTES + 1);
    localparam int RW = $clog2(NREPS + 1);
    localparam logic [IW-1:0] LAST_IDX = IW'(NBYTES - 1);
    localparam logic [RW-1:0] FULL_REPS = RW'(NREPS);

    logic [IW-1:0] dst_cnt;
    logic dst_ok;
    logic [IW-1:0] idx;
    logic [RW-1:0] reps;
    logic seen;

    // ********************************
    // byte selection
    // ********************************
    wire [7:0] want_dst = station_phys_address[8*dst_cnt +: 8];
    wire [7:0] want_seq = station_phys_address[8*idx +: 8];
    wire [7:0] want_first = station_phys_address[7:0];
    wire in_dst = rx.valid && (rx.start || dst_cnt != IW'(NBYTES));
    wire seq_hit = rx.valid && rx.data == want_seq;
    wire group_done = seq_hit && idx == LAST_IDX;
    wire first_hit = rx.data == want_first;
    // destination filter only, payload test is independent [RULE14]
    wire dst_pass = dst_ok || any_accept; // [RULE13]
    wire rep_pass = seen || (group_done && reps == FULL_REPS - RW'(1)); // [RULE15]

    // ********************************
    // tracking
    // ********************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dst_cnt <= '0;
            dst_ok <= 1'b0;
            idx <= '0;
            reps <= '0;
            seen <= 1'b0;
            frame_hit <= 1'b0;
        end else begin
            frame_hit <= rx.valid && rx.last && rx.good && mode_active && dst_pass && rep_pass;
            if (rx.valid && rx.start) begin
                dst_cnt <= IW'(1);
                dst_ok <= rx.data == want_first;
            end else if (in_dst) begin
                dst_cnt <= dst_cnt + IW'(1);
                dst_ok <= dst_ok && rx.data == want_dst;
            end
            // a broken run restarts, the mismatching byte may open a new one
            if (rx.valid && (rx.start || rx.last)) begin
                idx <= (!rx.last && first_hit) ? IW'(1) : '0;
                reps <= '0;
                seen <= 1'b0;
            end else if (group_done) begin
                idx <= '0;
                reps <= (reps == FULL_REPS) ? reps : reps + RW'(1);
                seen <= rep_pass;
            end else if (seq_hit) begin
                idx <= idx + IW'(1);
            end else if (rx.valid) begin
                idx <= first_hit ? IW'(1) : '0;
                reps <= '0;
            end
        end
    end
endmodule
`default_nettype wire

// ==== logic/ext_interrupt_wake_control.sv ====
// extended control and interrupt field group with wake frame detection
`timescale 1ns/10ps
`default_nettype none
module ext_interrupt_wake_control
    import ext_int_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // controller resets and stop
    input wire logic soft_reset,
    input wire logic stop_cmd,
    // register port
    input wire logic [ext_int_pkg::ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // bus master error events
    input wire ext_int_pkg::bus_err_s bus_err,
    input wire logic parity_response_enable,
    // pci status clear strobes
    input wire logic data_parity_status_clr,
    input wire logic rx_master_abort_status_clr,
    input wire logic rx_target_abort_status_clr,
    // transmitter events
    input wire logic excess_defer_evt,
    // receive stream
    input wire ext_int_pkg::rx_byte_s rx,
    input wire logic [47:0] station_phys_address,
    // interrupt gating from elsewhere
    input wire logic master_int_enable,
    // outputs
    output logic last_tx_int_enable,
    output logic wake_mode_active,
    output logic int_summary,
    output logic int_request_pin
);
    import ext_int_pkg::*;

    // ********************************
    // control bits
    // ********************************
    logic sys_err_enable;
    logic excess_defer_enable;
    logic wake_any_addr_accept;
    logic wake_any_addr_accept_dup;
    logic wake_frame_enable;
    logic wake_host_enable;
    logic wake_mode_select;

    // ********************************
    // flags
    // ********************************
    logic sys_err_flag;
    logic excess_defer_flag;
    logic wake_frame_flag;
    logic wake_hit;

    // ********************************
    // decode
    // ********************************
    wire sel_main = addr == REG_CTRL_INT;
    wire sel_aux = addr == REG_WAKE_AUX;
    wire wr_main = wr && sel_main;
    wire wr_aux = wr && sel_aux;
    wire w1c_sys = wr_main && wdata[BIT_SYS_FLAG];
    wire w1c_exd = wr_main && wdata[BIT_EXD_FLAG];
    wire w1c_wake = wr_main && wdata[BIT_WAKE_FLAG];

    // ********************************
    // event terms
    // ********************************
    // parity counts even with response disabled [RULE4]
    wire sys_err_evt = bus_err.parity || bus_err.master_abort || bus_err.target_abort; // [RULE3]
    // pci status clears feed nothing here on purpose [RULE6]
    wire status_clr_any = data_parity_status_clr || rx_master_abort_status_clr || rx_target_abort_status_clr;
    wire unused_ok = parity_response_enable ^ status_clr_any;
    wire wake_any_eff = wake_any_addr_accept || wake_any_addr_accept_dup; // [RULE16]
    wire next_mode = wake_host_enable && wake_mode_select; // [RULE22]

    // ********************************
    // interrupt terms
    // ********************************
    // system errors bypass the master enable, which the error itself drops [RULE5]
    wire sys_req = sys_err_flag && sys_err_enable;
    wire exd_req = excess_defer_flag && excess_defer_enable; // [RULE10]
    wire wake_req = wake_frame_flag && wake_frame_enable && master_int_enable; // [RULE19] [RULE21]
    wire next_summary = sys_req || exd_req || wake_req; // [RULE23]

    // ********************************
    // read mux
    // ********************************
    // reserved positions are driven to zero rather than left floating [RULE2]
    wire [31:0] main_word = {
        17'h0_0000,
        last_tx_int_enable,
        2'h0,
        sys_err_flag,
        sys_err_enable,
        2'h0,
        excess_defer_flag,
        excess_defer_enable,
        wake_any_addr_accept,
        wake_frame_flag,
        wake_frame_enable,
        wake_host_enable,
        wake_mode_select,
        1'h0
    };
    wire [31:0] aux_word = {25'h000_0000, wake_any_addr_accept_dup, 6'h00};
    wire [31:0] next_rdata = !rd ? 32'h0000_0000 :
        sel_main ? main_word :
        sel_aux ? aux_word : 32'h0000_0000;

    // ********************************
    // controls cleared by hard and soft reset
    // ********************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            last_tx_int_enable <= CTRL_INT_RESET[BIT_LAST_TX_EN];
            sys_err_enable <= CTRL_INT_RESET[BIT_SYS_EN];
            wake_any_addr_accept <= CTRL_INT_RESET[BIT_ANY_ADDR];
            wake_frame_enable <= CTRL_INT_RESET[BIT_WAKE_EN];
            wake_host_enable <= CTRL_INT_RESET[BIT_WAKE_HOST];
            wake_mode_select <= CTRL_INT_RESET[BIT_WAKE_MODE];
        end else if (soft_reset) begin
            // stop is not listed here, these survive it
            last_tx_int_enable <= 1'b0; // [RULE1]
            sys_err_enable <= 1'b0; // [RULE8]
            wake_any_addr_accept <= 1'b0; // [RULE17]
            wake_frame_enable <= 1'b0; // [RULE21]
            wake_host_enable <= 1'b0;
            wake_mode_select <= 1'b0;
        end else if (wr_main) begin
            last_tx_int_enable <= wdata[BIT_LAST_TX_EN]; // [RULE1]
            sys_err_enable <= wdata[BIT_SYS_EN]; // [RULE8]
            wake_any_addr_accept <= wdata[BIT_ANY_ADDR]; // [RULE13] [RULE14]
            wake_frame_enable <= wdata[BIT_WAKE_EN];
            wake_host_enable <= wdata[BIT_WAKE_HOST];
            wake_mode_select <= wdata[BIT_WAKE_MODE];
        end
    end

    // ********************************
    // control cleared only by hard reset
    // ********************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            excess_defer_enable <= CTRL_INT_RESET[BIT_EXD_EN]; // [RULE12]
        end else if (wr_main) begin
            excess_defer_enable <= wdata[BIT_EXD_EN];
        end
    end

    // ********************************
    // duplicate accept bit
    // ********************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wake_any_addr_accept_dup <= 1'b0;
        end else if (soft_reset) begin
            wake_any_addr_accept_dup <= 1'b0;
        end else if (wr_aux) begin
            wake_any_addr_accept_dup <= wdata[BIT_ANY_ADDR_DUP];
        end
    end

    // ********************************
    // status outputs and read data
    // ********************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 32'h0000_0000;
            int_summary <= 1'b0;
            wake_mode_active <= 1'b0;
        end else begin
            rdata <= next_rdata;
            int_summary <= next_summary; // [RULE23]
            wake_mode_active <= next_mode; // [RULE22]
        end
    end

    // pin follows the summary; one flop, no extra gating [RULE23]
    assign int_request_pin = int_summary;

    // ********************************
    // flag cells
    // ********************************
    // a set in the clearing cycle wins, so no event is lost
    sticky_flag u_sys_flag (
        .clock(clock),
        .rst_n(rst_n),
        .set_evt(sys_err_evt), // [RULE3]
        .clear_w1c(w1c_sys), // [RULE7]
        .clear_sync(soft_reset), // [RULE7]
        .flag(sys_err_flag)
    );

    sticky_flag u_exd_flag (
        .clock(clock),
        .rst_n(rst_n),
        .set_evt(excess_defer_evt), // [RULE9]
        .clear_w1c(w1c_exd), // [RULE11]
        .clear_sync(1'b0),
        .flag(excess_defer_flag)
    );

    sticky_flag u_wake_flag (
        .clock(clock),
        .rst_n(rst_n),
        .set_evt(wake_hit), // [RULE18]
        .clear_w1c(w1c_wake), // [RULE20]
        .clear_sync(soft_reset || stop_cmd), // [RULE20]
        .flag(wake_frame_flag)
    );

    // ********************************
    // wake frame recognition
    // ********************************
    wake_frame_matcher #(
        .NBYTES(ADDR_BYTES),
        .NREPS(ADDR_REPS)
    ) u_matcher (
        .clock(clock),
        .rst_n(rst_n),
        .rx(rx),
        .station_phys_address(station_phys_address),
        .any_accept(wake_any_eff), // [RULE16]
        .mode_active(wake_mode_active), // [RULE18]
        .frame_hit(wake_hit)
    );

    // ********************************
    // checks
    // ********************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence seq_sys_event;
        sys_err_evt && !unused_ok && !w1c_sys && !soft_reset;
    endsequence

    sequence seq_sys_quiet_clear;
        w1c_sys && !sys_err_evt;
    endsequence

    sequence seq_wake_kill;
        (stop_cmd || soft_reset) && !wake_hit;
    endsequence

    AST_SYS_SET: assert property (sys_err_evt |=> sys_err_flag) // [RULE3]
        else $error("system flag not set by bus error");

    AST_PARITY_ANY: assert property (bus_err.parity && !parity_response_enable |=> sys_err_flag) // [RULE4]
        else $error("parity error ignored without response enable");

    AST_SYS_PIN: assert property ( // [RULE5]
        sys_err_flag && sys_err_enable && !master_int_enable |=> int_request_pin)
        else $error("system request depends on master enable");

    AST_SYS_STATUS: assert property ( // [RULE6]
        sys_err_flag && status_clr_any && !w1c_sys && !soft_reset |=> sys_err_flag)
        else $error("status clear disturbed system flag");

    AST_SYS_W1C: assert property (seq_sys_quiet_clear |=> !sys_err_flag) // [RULE7]
        else $error("system flag survived write one");

    AST_SYS_STOP: assert property ( // [RULE7]
        sys_err_flag && stop_cmd && !soft_reset && !w1c_sys |=> sys_err_flag)
        else $error("stop cleared system flag");

    AST_EXD_SOFT: assert property ( // [RULE11] [RULE12]
        excess_defer_flag && excess_defer_enable && soft_reset && !wr_main
        |=> excess_defer_flag && excess_defer_enable)
        else $error("soft reset touched deferral bits");

    AST_EXD_PIN: assert property ( // [RULE9] [RULE10]
        excess_defer_evt && excess_defer_enable && !wr_main |-> ##2 int_request_pin)
        else $error("deferral event did not request within two cycles");

    AST_SOFT_CTRL: assert property ( // [RULE1] [RULE8] [RULE17] [RULE21]
        soft_reset |=> !last_tx_int_enable && !sys_err_enable && !wake_any_addr_accept && !wake_frame_enable)
        else $error("soft reset left a control bit set");

    AST_STOP_KEEP: assert property ( // [RULE1] [RULE17]
        stop_cmd && !soft_reset && !wr_main |=> $stable(last_tx_int_enable) && $stable(wake_any_addr_accept))
        else $error("stop changed a control bit");

    AST_WAKE_KILL: assert property (seq_wake_kill |=> !wake_frame_flag) // [RULE20]
        else $error("wake flag survived stop or soft reset");

    AST_WAKE_GATE: assert property (
        !master_int_enable && !sys_req && !exd_req |=> !int_summary) // [RULE19]
        else $error("wake request passed without master enable");

    AST_MODE: assert property (wake_host_enable && wake_mode_select |=> wake_mode_active) // [RULE22]
        else $error("wake mode not entered");

    AST_RD_IDLE: assert property (!rd |=> rdata == 32'h0000_0000) // [RULE2]
        else $error("read data outside its cycle");

    AST_RSVD: assert property (rd && sel_main |=> rdata[13:12] == 2'h0 && rdata[9:8] == 2'h0) // [RULE2]
        else $error("reserved bits read non zero");

    AST_SYS_HOLD: assert property ( // [RULE7]
        seq_sys_event |=> sys_err_flag [*2] or (w1c_sys || soft_reset))
        else $error("system flag dropped without a clear");

    // ********************************
    // flag, gate and reset checks
    // ********************************
    AST_EXD_SET: assert property (excess_defer_evt |=> excess_defer_flag) // [RULE9]
        else $error("deferral flag not set");

    AST_EXD_W1C: assert property (w1c_exd && !excess_defer_evt |=> !excess_defer_flag) // [RULE11]
        else $error("deferral flag kept");

    AST_EXD_KEEP: assert property ( // [RULE11]
        excess_defer_flag && (stop_cmd || soft_reset) && !w1c_exd |=> excess_defer_flag)
        else $error("deferral flag lost");

    AST_EXD_HARD: assert property (soft_reset && !wr_main |=> $stable(excess_defer_enable)) // [RULE12]
        else $error("deferral enable moved");

    AST_WAKE_SET: assert property (wake_hit |=> wake_frame_flag) // [RULE18]
        else $error("wake flag not set");

    AST_WAKE_W1C: assert property (w1c_wake && !wake_hit |=> !wake_frame_flag) // [RULE20]
        else $error("wake flag kept");

    AST_WAKE_PIN: assert property ( // [RULE19] [RULE21]
        wake_frame_flag && wake_frame_enable && master_int_enable |=> int_request_pin)
        else $error("wake request missing");

    AST_MODE_OFF: assert property (!(wake_host_enable && wake_mode_select) |=> !wake_mode_active) // [RULE22]
        else $error("wake mode without both bits");

    AST_STOP_EN: assert property ( // [RULE8] [RULE21]
        stop_cmd && !soft_reset && !wr_main |=> $stable(sys_err_enable) && $stable(wake_frame_enable))
        else $error("stop moved an enable");

    AST_DUP_SOFT: assert property (soft_reset |=> !wake_any_addr_accept_dup) // [RULE16] [RULE17]
        else $error("duplicate accept kept");

endmodule
`default_nettype wire

// ==== tb/wake_frame_source.sv ====
// receive-side frame source standing in for the network
`timescale 1ns/10ps
`default_nettype none
module wake_frame_source
    import ext_int_pkg::*;
(
    // clock
    input wire logic clock,
    // byte stream into the block
    output var ext_int_pkg::rx_byte_s rx
);
    // ********************************
    // frame sender
    // ********************************
    initial rx = '0;
    // dest bytes, reps copies of the address, then a tail byte with last and good
    task automatic send(input logic [47:0] dest, input logic [47:0] sa, input int reps, input logic good);
        int n;
        logic [7:0] b;
        n = 7 + 6 * reps;
        for (int i = 0; i < n; i++) begin
            @(posedge clock);
            b = (i < 6) ? dest[8*i +: 8] : (i < n - 1) ? sa[8*((i-6)%6) +: 8] : 8'hA5;
            rx <= '{valid: 1'b1, start: i == 0, last: i == n - 1, good: good && i == n - 1, data: b};
        end
        // idle bytes show the inverse, so a stale copy never looks valid
        @(posedge clock);
        rx <= '{valid: 1'b0, start: 1'b0, last: 1'b0, good: 1'b0, data: ~b};
    endtask
endmodule
`default_nettype wire

// ==== tb/tb_ext_interrupt_wake_control.sv ====
// self-checking bench for the extended control and interrupt group
`timescale 1ns/10ps
`default_nettype none
module tb_ext_interrupt_wake_control
    import ext_int_pkg::*;
;
    // ********************************
    // stimulus and checking state
    // ********************************
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [31:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [8:0] ev_vec = '0;
    logic parity_response_enable = 1'b0;
    logic master_int_enable = 1'b0;
    logic last_tx_int_enable;
    logic wake_mode_active;
    logic int_summary;
    logic int_request_pin;
    rx_byte_s rx;
    logic [47:0] sa;
    logic [31:0] exp_q[$];
    logic rd_prev = 1'b0;
    int seed = 73;
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [31:0] rw_all;
    logic [31:0] wk;

    always #50 clock = ~clock;

    ext_interrupt_wake_control dut (
        .clock(clock), .rst_n(rst_n), .soft_reset(ev_vec[4]), .stop_cmd(ev_vec[5]),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .bus_err(ev_vec[2:0]), .parity_response_enable(parity_response_enable),
        .data_parity_status_clr(ev_vec[6]), .rx_master_abort_status_clr(ev_vec[7]),
        .rx_target_abort_status_clr(ev_vec[8]), .excess_defer_evt(ev_vec[3]),
        .rx(rx), .station_phys_address(sa), .master_int_enable(master_int_enable),
        .last_tx_int_enable(last_tx_int_enable), .wake_mode_active(wake_mode_active),
        .int_summary(int_summary), .int_request_pin(int_request_pin)
    );

    wake_frame_source src (.clock(clock), .rx(rx));

    // ********************************
    // tasks
    // ********************************
    function automatic logic [31:0] bv(input int b);
        return 32'h1 << b;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask

    // expectation queued now, compared by the watcher when rdata appears
    task automatic rd_reg(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back(exp);
        @(posedge clock);
        rd <= 1'b0;
    endtask

    // one-cycle pulse on an event line: 0-2 bus errors, 3 deferral, 4 soft, 5 stop, 6-8 status clears
    task automatic ev(input int k);
        @(posedge clock);
        ev_vec <= 9'h001 << k;
        @(posedge clock);
        ev_vec <= '0;
    endtask

    // summary is registered, so it settles one edge after the flag or gate
    task automatic pin_is(input logic e);
        @(posedge clock);
        #1;
        chk({30'h0, int_summary, int_request_pin}, {30'h0, e, e});
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ********************************
    // watcher and timeout
    // ********************************
    always @(negedge clock) begin
        if (rd_prev) begin
            if (exp_q.size() == 0) begin
                chk(rdata, 32'hFFFF_FFFF);
            end else begin
                chk(rdata, exp_q.pop_front());
            end
        end
        rd_prev = rd;
    end

    always @(posedge clock) begin
        cyc++;
        if (cyc == 6000) begin
            err_count++;
            results();
        end
    end

    // ********************************
    // main sequence
    // ********************************
    initial begin
        sa = 48'({$random(seed), $random(seed)});
        rw_all = bv(BIT_LAST_TX_EN) | bv(BIT_SYS_EN) | bv(BIT_EXD_EN) | bv(BIT_ANY_ADDR) | bv(BIT_WAKE_EN)
            | bv(BIT_WAKE_HOST) | bv(BIT_WAKE_MODE);
        wk = bv(BIT_WAKE_HOST) | bv(BIT_WAKE_MODE) | bv(BIT_WAKE_EN);
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        rd_reg(REG_CTRL_INT, CTRL_INT_RESET);
        rd_reg(REG_WAKE_AUX, 32'h0);
        wr_reg(REG_CTRL_INT, rw_all);
        ev(5);
        rd_reg(REG_CTRL_INT, rw_all);
        wr_reg(12'h100, 32'hFFFF_FFFF);
        rd_reg(12'h100, 32'h0);
        rd_reg(REG_CTRL_INT, rw_all);
        chk({30'h0, last_tx_int_enable, wake_mode_active}, 32'h3);
        // system errors, with the master gate and parity response both off
        for (int k = 0; k < 3; k++) begin
            ev(k);
            pin_is(1'b1);
            ev(6 + k);
            rd_reg(REG_CTRL_INT, rw_all | bv(BIT_SYS_FLAG));
            wr_reg(REG_CTRL_INT, rw_all);
            rd_reg(REG_CTRL_INT, rw_all | bv(BIT_SYS_FLAG));
            wr_reg(REG_CTRL_INT, rw_all | bv(BIT_SYS_FLAG));
            pin_is(1'b0);
        end
        // deferral flag survives soft reset and stop, system flag is cleared by the soft reset
        ev(3);
        pin_is(1'b1);
        parity_response_enable <= 1'b1;
        ev(2);
        ev(4);
        ev(5);
        rd_reg(REG_CTRL_INT, bv(BIT_EXD_FLAG) | bv(BIT_EXD_EN));
        wr_reg(REG_CTRL_INT, bv(BIT_EXD_FLAG) | bv(BIT_EXD_EN));
        pin_is(1'b0);
        rd_reg(REG_CTRL_INT, bv(BIT_EXD_EN));
        // wake frames
        master_int_enable <= 1'b1;
        wr_reg(REG_CTRL_INT, wk);
        src.send(sa, sa, ADDR_REPS, 1'b1);
        @(posedge clock);
        pin_is(1'b1);
        rd_reg(REG_CTRL_INT, wk | bv(BIT_WAKE_FLAG));
        @(posedge clock);
        master_int_enable <= 1'b0;
        pin_is(1'b0);
        ev(5);
        rd_reg(REG_CTRL_INT, wk);
        src.send(48'hFFFF_FFFF_FFFF, sa, ADDR_REPS, 1'b1);
        rd_reg(REG_CTRL_INT, wk);
        wr_reg(REG_WAKE_AUX, bv(BIT_ANY_ADDR_DUP));
        src.send(48'hFFFF_FFFF_FFFF, sa, ADDR_REPS, 1'b1);
        rd_reg(REG_CTRL_INT, wk | bv(BIT_WAKE_FLAG));
        wr_reg(REG_CTRL_INT, wk | bv(BIT_WAKE_FLAG) | bv(BIT_ANY_ADDR));
        wr_reg(REG_WAKE_AUX, 32'h0);
        rd_reg(REG_CTRL_INT, wk | bv(BIT_ANY_ADDR));
        src.send(48'h0000_0000_0001, sa, ADDR_REPS, 1'b1);
        rd_reg(REG_CTRL_INT, wk | bv(BIT_ANY_ADDR) | bv(BIT_WAKE_FLAG));
        wr_reg(REG_CTRL_INT, wk | bv(BIT_ANY_ADDR) | bv(BIT_WAKE_FLAG));
        src.send(48'hFFFF_FFFF_FFFF, sa, ADDR_REPS - 1, 1'b1);
        src.send(48'hFFFF_FFFF_FFFF, sa, ADDR_REPS, 1'b0);
        rd_reg(REG_CTRL_INT, wk | bv(BIT_ANY_ADDR));
        wr_reg(REG_CTRL_INT, bv(BIT_ANY_ADDR) | bv(BIT_WAKE_EN) | bv(BIT_WAKE_MODE));
        src.send(sa, sa, ADDR_REPS, 1'b1);
        rd_reg(REG_CTRL_INT, bv(BIT_ANY_ADDR) | bv(BIT_WAKE_EN) | bv(BIT_WAKE_MODE));
        wr_reg(REG_CTRL_INT, wk);
        src.send(sa, sa, ADDR_REPS, 1'b1);
        ev(4);
        rd_reg(REG_CTRL_INT, 32'h0);
        repeat (2) @(posedge clock);
        results();
    end
endmodule
`default_nettype wire
